// *** tb_top.sv ***
// self-checking testbench of the temperature sensor serial port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int              CONV = 200;
   localparam logic [15:0]     ID   = 16'h5a0f;  // value is arbitrary

   logic        clk_i;
   logic        rst_i;
   logic [13:0] temp;
   logic        flt = 1'b0;
   wire  logic  dout;
   wire  logic  doe;
   wire  logic  tvalid;
   wire  logic  sdown;
   wire  logic  sc;
   wire  logic  sel_n;
   wire  logic  hd;
   wire  logic  hoe;
   wire  logic  pin;
   int          mismatches;
   int          num_checks;

   //------------------------------------------------------------------
   // pin resolution: an undriven wire toggles every cycle
   //------------------------------------------------------------------
   assign pin = doe ? dout : (hoe ? hd : flt);

   tsp_serial_port #(.CONV_CYCLES(CONV), .ID_WORD(ID)) dut (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .serial_clock_pin_i (sc),
      .select_n_i         (sel_n),
      .data_i             (pin),
      .data_o             (dout),
      .data_oe_o          (doe),
      .temp_i             (temp),
      .temp_valid_o       (tvalid),
      .shutdown_o         (sdown)
   );

   tsp_host_model host (
      .clk_i   (clk_i),
      .pin_i   (pin),
      .sc_o    (sc),
      .sel_n_o (sel_n),
      .d_o     (hd),
      .oe_o    (hoe)
   );

   //------------------------------------------------------------------
   // clock, floating pattern and watchdog
   //------------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   always @(negedge clk_i) flt <= ~flt;

   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      give_verdict();
   end

   //------------------------------------------------------------------
   // shared helpers
   //------------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   // waits out two full conversions so the holding register is settled
   task automatic wait_conv();
      repeat (2 * CONV + 20) @(negedge clk_i);
   endtask : wait_conv

   //------------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------------
   task automatic t_reset();
      check("shutdown", {15'h0, sdown}, 16'h0000);
      check("valid", {15'h0, tvalid}, 16'h0000);
      check("oe", {15'h0, doe}, 16'h0000);
   endtask : t_reset

   task automatic t_invalid();
      logic [15:0] r;
      temp = 14'h0320;
      check("valid", {15'h0, tvalid}, 16'h0000);
      host.xfer(16, 0, 16'h0000, r);
      check("early word", r, 16'h0003);
      check("valid", {15'h0, tvalid}, 16'h0001);
   endtask : t_invalid

   task automatic t_temps();
      logic [13:0] tv [4] = '{14'h0320, 14'h3ce0, 14'h12c0, 14'h3fff};
      logic [15:0] ex [4] = '{16'h0c83, 16'hf383, 16'h4b03, 16'hffff};
      logic [15:0] r;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_i);
         temp = tv[i];
         wait_conv();
         host.xfer(16, 0, 16'h0000, r);
         check("temp word", r, ex[i]);
         check("valid", {15'h0, tvalid}, 16'h0001);
      end
   endtask : t_temps

   task automatic t_early();
      logic [15:0] r;
      @(negedge clk_i);
      temp = 14'h0320;
      wait_conv();
      host.xfer(4, 0, 16'h0000, r);
      check("nibble", r, 16'h0000);
      check("oe", {15'h0, doe}, 16'h0000);
      host.xfer(8, 0, 16'h0000, r);
      check("byte", r, 16'h000c);
      host.xfer(16, 0, 16'h0000, r);
      check("word after abort", r, 16'h0c83);
   endtask : t_early

   task automatic t_shutdown();
      logic [15:0] r;
      host.xfer(16, 16, 16'h00ff, r);
      check("tx phase", r, 16'h0c83);
      check("shutdown", {15'h0, sdown}, 16'h0001);
      check("valid", {15'h0, tvalid}, 16'h0000);
      host.xfer(16, 0, 16'h0000, r);
      check("id", r, ID);
      host.xfer(16, 8, 16'h005a, r);
      check("id again", r, ID);
      check("shutdown", {15'h0, sdown}, 16'h0001);
      host.xfer(16, 16, 16'hff00, r);
      check("id third", r, ID);
      check("shutdown", {15'h0, sdown}, 16'h0000);
      check("valid", {15'h0, tvalid}, 16'h0000);
      wait_conv();
      host.xfer(16, 0, 16'h0000, r);
      check("temp word", r, 16'h0c83);
   endtask : t_shutdown

   //------------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------------
   initial begin
      mismatches = 0;
      num_checks = 0;
      temp       = 14'h0000;
      rst_i      = 1'b1;
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      t_reset();
      t_invalid();
      t_temps();
      t_early();
      t_shutdown();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire

// *** tsp_host_model.sv ***
// host serial master model that frames transfers on the shared data pin
`default_nettype none
module tsp_host_model (
   input  wire logic clk_i,
   input  wire logic pin_i,
   output logic      sc_o,
   output logic      sel_n_o,
   output logic      d_o,
   output logic      oe_o
);
   timeunit 1ns;
   timeprecision 100ps;

   //------------------------------------------------------------------
   // idle state: select high, serial clock parked low, pin released
   //------------------------------------------------------------------
   initial begin
      sc_o    = 1'b0;
      sel_n_o = 1'b1;
      d_o     = 1'b0;
      oe_o    = 1'b0;
   end

   //------------------------------------------------------------------
   // one frame: ntx bits read, then nrx bits written msb first
   //------------------------------------------------------------------
   // the serial clock stands still outside frames; half period is 80 ns
   task automatic xfer(input int ntx, input int nrx, input logic [15:0] wdata, output logic [15:0] rdata);
      rdata = 16'h0000;
      @(negedge clk_i);
      sel_n_o <= 1'b0;
      repeat (24) @(negedge clk_i);               // select to first rise, over 100 ns
      for (int k = 0; k < ntx + nrx; k++) begin
         if (k >= ntx) begin
            oe_o <= 1'b1;
            d_o  <= wdata[nrx - 1 - (k - ntx)];
         end
         repeat (16) @(negedge clk_i);
         sc_o <= 1'b1;
         if (k < ntx) begin
            rdata = {rdata[14:0], pin_i};
         end
         repeat (16) @(negedge clk_i);
         sc_o <= 1'b0;
      end
      repeat (16) @(negedge clk_i);
      sel_n_o <= 1'b1;
      oe_o    <= 1'b0;
      repeat (40) @(negedge clk_i);
   endtask : xfer
endmodule : tsp_host_model
`default_nettype wire

// *** tsp_map.svh ***
// constants of the temperature sensor serial port
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - after power-up, continuous conversion is selected and shutdown is inactive
// - the word shifted out before the first conversion ends is not valid
// - releasing reset returns every register to its continuous-mode default
// - temperature is a 14-bit two's-complement value, 0.03125 degrees per count
// - read word holds temperature in bits 15..2, bits 1..0 always one
// - most significant byte first, most significant bit first
// - a received low byte of all ones enters shutdown mode
// - the serial port keeps working during shutdown and accepts writes
// - in shutdown every read returns the fixed identification word
// - output changes on falling clock edges, input captured on rising edges
// - a transaction spans select falling to the next select rising
// - a read-only transaction is 16 clocks shifting one whole word
// - read-and-write uses 32 clocks, 16 transmit then 16 receive
// - while select is high the data pin is released
// - first bit driven when select falls, later bits on falling edges
// - select rising during transmit stops shifting and releases the pin
// - a conversion ending mid-frame reaches the shift register after select rises
// - receive bits enter an 8-bit register; last eight before select rises count
// - received all zeros selects continuous mode; other codes are ignored
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

`define TSP_WORD_W        16
`define TSP_TEMP_W        14
`define TSP_RX_W          8
`define TSP_CNT_W         5
`define TSP_TX_LAST       5'h0f
`define TSP_RX_FULL       5'h10
`define TSP_RX_MIN        5'h08
`define TSP_CMD_SHUTDOWN  8'hff
`define TSP_CMD_CONT      8'h00
`define TSP_PAD_BITS      2'h3
`define TSP_ID_DEFAULT    16'h4a5b
`define TSP_CONV_TIME_MS  228
`define TSP_CLK_KHZ       200000
`define TSP_SYNC_STAGES   3

`endif

// *** tsp_pkg.sv ***
// types of the temperature sensor serial port
`default_nettype none
package tsp_pkg;
   typedef enum logic [1:0] {TSP_PH_IDLE, TSP_PH_TX, TSP_PH_RX} tsp_phase_e;
   typedef enum logic {TSP_MODE_CONT, TSP_MODE_SHUTDOWN} tsp_mode_e;
endpackage : tsp_pkg
`default_nettype wire

// *** tsp_serial_port.sv ***
// serial slave port and conversion sequencing of the temperature sensor
`include "tsp_map.svh"
`default_nettype none
module tsp_serial_port #(
   parameter int                    CONV_CYCLES = `TSP_CONV_TIME_MS * `TSP_CLK_KHZ,
   parameter logic [`TSP_WORD_W-1:0] ID_WORD    = `TSP_ID_DEFAULT  // value is arbitrary
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   serial_clock_pin_i,
   input  wire logic                   select_n_i,
   input  wire logic                   data_i,
   output logic                        data_o,
   output logic                        data_oe_o,
   input  wire logic [`TSP_TEMP_W-1:0] temp_i,
   output logic                        temp_valid_o,
   output logic                        shutdown_o
);
   localparam int CONV_W = $clog2(CONV_CYCLES + 1);

   //----------------------------------------------------------------------
   // declarations
   //----------------------------------------------------------------------
   logic [2:0]                 sync_q;
   logic                       sc_q;
   logic                       sel_n_q;
   logic                       din_q;
   logic                       sc_prev_r;
   logic                       sel_prev_r;
   logic                       sc_rise;
   logic                       sc_fall;
   logic                       sel_fall;
   logic                       sel_rise;
   tsp_pkg::tsp_phase_e        phase_r;
   tsp_pkg::tsp_phase_e        phase_nxt;
   tsp_pkg::tsp_mode_e         mode_r;
   tsp_pkg::tsp_mode_e         mode_nxt;
   logic [`TSP_CNT_W-1:0]      bit_cnt_r;
   logic [`TSP_CNT_W-1:0]      bit_cnt_nxt;
   logic [`TSP_CNT_W-1:0]      rx_cnt_r;
   logic [`TSP_CNT_W-1:0]      rx_cnt_nxt;
   logic [`TSP_RX_W-1:0]       rx_r;
   logic [`TSP_RX_W-1:0]       rx_nxt;
   logic [`TSP_WORD_W-1:0]     shreg_r;
   logic [`TSP_WORD_W-1:0]     shreg_nxt;
   logic [`TSP_WORD_W-1:0]     load_word;
   logic [CONV_W-1:0]          conv_cnt_r;
   logic [CONV_W-1:0]          conv_cnt_nxt;
   logic [`TSP_TEMP_W-1:0]     temp_hold_r;
   logic [`TSP_TEMP_W-1:0]     temp_hold_nxt;
   logic                       valid_r;
   logic                       valid_nxt;
   logic                       in_tx;
   logic                       in_rx;
   logic                       shutdown;
   logic                       conv_done;
   logic                       shift_out;
   logic                       shift_in;
   logic                       last_tx_rise;
   logic                       cmd_ok;
   logic                       cmd_sd;
   logic                       cmd_cont;

   //----------------------------------------------------------------------
   // pin synchronisers and edge detection
   //----------------------------------------------------------------------
   tsp_sync #(
      .WIDTH   (3),
      .RST_VAL (3'h2)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({data_i, select_n_i, serial_clock_pin_i}),
      .q_o   (sync_q)
   );

   // four flops cost four clocks of latency; a serial clock period of 32 clocks leaves ample margin
   // filtered pin levels
   assign sc_q    = sync_q[0];
   assign sel_n_q = sync_q[1];
   assign din_q   = sync_q[2];

   // previous levels for edge finding
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sc_prev_r  <= 1'b0;
         sel_prev_r <= 1'b1;
      end else begin
         sc_prev_r  <= sc_q;
         sel_prev_r <= sel_n_q;
      end
   end

   // edges of serial clock and select
   assign sc_rise  = sc_q & ~sc_prev_r;
   assign sc_fall  = ~sc_q & sc_prev_r;
   assign sel_fall = ~sel_n_q & sel_prev_r;
   assign sel_rise = sel_n_q & ~sel_prev_r;

   //----------------------------------------------------------------------
   // frame decode
   //----------------------------------------------------------------------
   assign in_tx        = (phase_r == tsp_pkg::TSP_PH_TX);
   assign in_rx        = (phase_r == tsp_pkg::TSP_PH_RX);
   assign shutdown     = (mode_r == tsp_pkg::TSP_MODE_SHUTDOWN);
   assign last_tx_rise = in_tx & sc_rise & (bit_cnt_r == `TSP_TX_LAST);
   assign shift_out    = in_tx & ~sel_n_q & sc_fall & (bit_cnt_r != '0);
   assign shift_in     = in_rx & ~sel_n_q & sc_rise;
   assign cmd_ok       = in_rx & sel_rise & (rx_cnt_r >= `TSP_RX_MIN);
   assign cmd_sd       = cmd_ok & (rx_r == `TSP_CMD_SHUTDOWN);
   assign cmd_cont     = cmd_ok & (rx_r == `TSP_CMD_CONT);
   assign load_word    = shutdown ? ID_WORD : {temp_hold_r, `TSP_PAD_BITS};

   //----------------------------------------------------------------------
   // frame phase machine
   //----------------------------------------------------------------------
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         tsp_pkg::TSP_PH_IDLE: begin
            if (sel_fall) phase_nxt = tsp_pkg::TSP_PH_TX;
         end
         tsp_pkg::TSP_PH_TX: begin
            if (sel_n_q) phase_nxt = tsp_pkg::TSP_PH_IDLE;
            else if (last_tx_rise) phase_nxt = tsp_pkg::TSP_PH_RX;
         end
         tsp_pkg::TSP_PH_RX: begin
            if (sel_n_q) phase_nxt = tsp_pkg::TSP_PH_IDLE;
         end
         default: begin
            phase_nxt = tsp_pkg::TSP_PH_IDLE;
         end
      endcase
   end

   // bit counters: transmit rises, then receive bits saturating at sixteen
   assign bit_cnt_nxt = sel_fall ? '0 :
                        (in_tx & sc_rise) ? bit_cnt_r + `TSP_CNT_W'(1) : bit_cnt_r;
   assign rx_cnt_nxt  = sel_fall ? '0 :
                        (shift_in & (rx_cnt_r != `TSP_RX_FULL)) ? rx_cnt_r + `TSP_CNT_W'(1) : rx_cnt_r;

   // receive shift register keeps the last eight bits
   assign rx_nxt = shift_in ? {rx_r[`TSP_RX_W-2:0], din_q} : rx_r;

   // reloading only in idle keeps a conversion that ends mid-frame
   // from corrupting the word that is being sent
   // output shift register: reloaded only between frames, shifts msb first
   assign shreg_nxt = (phase_r == tsp_pkg::TSP_PH_IDLE) ? load_word :
                      shift_out ? {shreg_r[`TSP_WORD_W-2:0], 1'b1} : shreg_r;

   // mode: shutdown on all ones, continuous on all zeros, others ignored
   assign mode_nxt = cmd_sd ? tsp_pkg::TSP_MODE_SHUTDOWN :
                     cmd_cont ? tsp_pkg::TSP_MODE_CONT : mode_r;

   //----------------------------------------------------------------------
   // conversion sequencing
   //----------------------------------------------------------------------
   // conversions stop in shutdown and restart from zero on leaving it,
   // so the first word after wake-up waits a full conversion
   assign conv_done     = ~shutdown & (conv_cnt_r == CONV_W'(CONV_CYCLES - 1));
   assign conv_cnt_nxt  = (shutdown | conv_done) ? '0 : conv_cnt_r + CONV_W'(1);
   assign temp_hold_nxt = conv_done ? temp_i : temp_hold_r;
   assign valid_nxt     = conv_done ? 1'b1 : (cmd_sd ? 1'b0 : valid_r);

   // frame registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_r   <= tsp_pkg::TSP_PH_IDLE;
         bit_cnt_r <= '0;
         rx_cnt_r  <= '0;
         rx_r      <= '0;
         shreg_r   <= '0;
      end else begin
         phase_r   <= phase_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         rx_cnt_r  <= rx_cnt_nxt;
         rx_r      <= rx_nxt;
         shreg_r   <= shreg_nxt;
      end
   end

   // mode and conversion registers, continuous mode out of reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_r      <= tsp_pkg::TSP_MODE_CONT;
         conv_cnt_r  <= '0;
         temp_hold_r <= '0;
         valid_r     <= 1'b0;
      end else begin
         mode_r      <= mode_nxt;
         conv_cnt_r  <= conv_cnt_nxt;
         temp_hold_r <= temp_hold_nxt;
         valid_r     <= valid_nxt;
      end
   end

   //----------------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------------
   // the enable follows the filtered select, so the pin is freed
   // a few clocks after select rises, well inside the release time
   assign data_o       = shreg_r[`TSP_WORD_W-1];
   assign data_oe_o    = in_tx & ~sel_n_q;
   assign temp_valid_o = valid_r;
   assign shutdown_o   = shutdown;

   //----------------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // pin released while select is high
   AST_RELEASE_IDLE: assert property (sel_n_q |-> !data_oe_o)
      else $error("data pin driven while select high");

   // select falling drives the first bit of the loaded word at once
   AST_FIRST_BIT: assert property (sel_fall |=> data_oe_o && data_o == $past(load_word[`TSP_WORD_W-1]))
      else $error("first bit not driven after select fall");

   // each falling clock in transmit after the first rising one advances the word by one bit
   AST_SHIFT_MSB: assert property (shift_out |=> data_o == $past(shreg_r[`TSP_WORD_W-2]))
      else $error("bit order wrong on falling clock");

   // shift register holds inside a frame once transmit has ended, and on the first transmit cycle
   AST_HOLD_FRAME: assert property (!sel_n_q && !in_tx ##1 !sel_n_q && !sc_fall |=> $stable(shreg_r))
      else $error("shift register disturbed during frame");

   // in shutdown the identification word is loaded
   AST_ID_WORD: assert property (shutdown && sel_fall |=> shreg_r == ID_WORD)
      else $error("identification word not loaded in shutdown");

   // temperature words always end in two ones
   AST_PAD_ONES: assert property (!shutdown && sel_fall |=> shreg_r[1:0] == `TSP_PAD_BITS)
      else $error("low bits of temperature word not one");

   // sixteenth rising edge ends transmit and frees the pin
   AST_RX_PHASE: assert property (last_tx_rise && !sel_n_q |=> in_rx && !data_oe_o)
      else $error("receive phase not entered after sixteen clocks");

   // select rising ends the frame and releases the pin
   AST_ABORT: assert property (sel_rise |=> phase_r == tsp_pkg::TSP_PH_IDLE ##0 !data_oe_o ##1 !data_oe_o)
      else $error("frame not ended on select rise");

   // received bits enter the receive register in order
   AST_RX_SHIFT: assert property (shift_in |=> rx_r == {$past(rx_r[`TSP_RX_W-2:0]), $past(din_q)})
      else $error("receive bit lost");

   // command decode at frame end
   AST_SD_ENTER: assert property (cmd_sd && !conv_done |=> shutdown_o && !temp_valid_o)
      else $error("shutdown not entered");
   AST_CONT_ENTER: assert property (cmd_cont |=> !shutdown_o)
      else $error("continuous mode not entered");

   // conversion end captures temperature and restarts the count
   AST_CONV_END: assert property (conv_done |=> temp_hold_r == $past(temp_i) && conv_cnt_r == '0 && temp_valid_o)
      else $error("conversion result not captured");

   // validity only ever rises on a conversion end
   AST_VALID_CAUSE: assert property ($rose(valid_r) |-> $past(conv_done))
      else $error("valid raised without conversion");

   // first cycle after reset release is continuous mode
   AST_RESET_MODE: assert property ($past(rst_i) |-> !shutdown_o && !temp_valid_o)
      else $error("reset did not select continuous mode");

   // a conversion ending with the shutdown command keeps valid set, so the mode is checked alone
   AST_SD_MODE: assert property (cmd_sd |=> shutdown_o)
      else $error("shutdown mode not taken");

   // codes other than all ones or all zeros leave the mode alone
   AST_IGNORE_CODE: assert property (cmd_ok && !cmd_sd && !cmd_cont |=> $stable(mode_r))
      else $error("mode changed on an undefined code");

   // fewer than eight received bits carry no command
   AST_SHORT_CMD: assert property (in_rx && sel_rise && (rx_cnt_r < `TSP_RX_MIN) |=> $stable(mode_r))
      else $error("mode changed on a short receive phase");

   // receive count never runs past sixteen
   AST_RX_SAT: assert property (in_rx |-> rx_cnt_r <= `TSP_RX_FULL)
      else $error("receive count overran");

   // a new frame restarts both bit counters
   AST_CNT_CLEAR: assert property (sel_fall |=> bit_cnt_r == '0 && rx_cnt_r == '0)
      else $error("bit counters not cleared at frame start");

   // between frames the shift register follows the word to be sent
   AST_IDLE_LOAD: assert property (phase_r == tsp_pkg::TSP_PH_IDLE |=> shreg_r == $past(load_word))
      else $error("shift register not reloaded between frames");

   // a falling clock before the first rising one shifts nothing
   AST_NO_EARLY_SHIFT: assert property (in_tx && sc_fall && bit_cnt_r == '0 |=> $stable(shreg_r))
      else $error("bit shifted before the first rising clock");

   // the holding register moves only at a conversion end
   AST_HOLD_STABLE: assert property (!conv_done |=> $stable(temp_hold_r))
      else $error("holding register changed outside conversion end");

   // validity once set is lost only through the shutdown command
   AST_VALID_KEEP: assert property (valid_r && !cmd_sd |=> valid_r)
      else $error("valid dropped without shutdown command");

   // conversions stand still in shutdown
   AST_SD_NO_CONV: assert property (shutdown |=> conv_cnt_r == '0)
      else $error("conversion counter running in shutdown");

endmodule : tsp_serial_port
`default_nettype wire

// *** tsp_sync.sv ***
// three-stage input synchroniser with agreement filter
`default_nettype none
module tsp_sync #(
   parameter int           WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   genvar g;
   //----------------------------------------------------------------------
   // per-bit chain
   //----------------------------------------------------------------------
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic q_r;
         // stage one feeds stage two only; output moves when two and three agree
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               s1_r <= RST_VAL[g];
               s2_r <= RST_VAL[g];
               s3_r <= RST_VAL[g];
               q_r  <= RST_VAL[g];
            end else begin
               s1_r <= d_i[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) q_r <= s3_r;
            end
         end
         assign q_o[g] = q_r;
      end
   endgenerate
endmodule : tsp_sync
`default_nettype wire
